// >>> rsr_settings_report.sv
/*
  Run-time settings report block: takes 64-byte command reports, answers
  the set-settings and get-settings commands with 64-byte replies, keeps
  the settings in registers and drives the indicators and clock output.
  Assumes command bytes, reply handshake, register strobes and activity
  inputs are synchronous to SYS_CLK_IN.
*/
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rsr_consts.svh"

// Behaviour
// R1: Set-settings reply: byte 0 is 0x60, byte 1 is 0x00, rest undefined.
// R2: Host asks for settings with code 0x61 and zero bytes 1 to 63.
// R3: Get-settings reply: byte 0 is 0x61, byte 1 is 0x00.
// R4: Reply byte 2 is chip area length, byte 3 is pin area length.
// R5: Byte 4 bit 7 reports the serial-number enable.
// R6: Byte 4 bit 6 is receive indicator idle level; inverted while receiving.
// R7: Byte 4 bit 5 is transmit indicator idle level; inverted while sending.
// R8: Byte 4 bit 4 is I2C indicator idle level; inverted during traffic.
// R9: Byte 4 bit 3 is suspend indicator level; inverted in suspend.
// R10: Byte 4 bit 2 is configured indicator level; inverted once configured.
// R11: Byte 4 bits 1-0: security mode 00 open, 01 password, 10 locked.
// R12: Byte 5 bits 4-3 set clock duty, bits 2-0 the clock divider.
// R13: Byte 6 bits 7-6 pick reference: 4.096, 2.048, 1.024 V or off.
// R14: Byte 6 bit 5 picks internal reference generator or supply rail.
// R15: Byte 6 bits 4-0 report the power-up DAC code.
// R16: Byte 7 bits 6 and 5 report negative and positive interrupt edges.
// R17: Exactly one 64-byte reply per accepted command, after full receipt.
module rsr_settings_report (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [7:0] CMD_BYTE_IN,
  output logic CMD_READY_OUT,
  output logic RPL_VALID_OUT,
  output logic [7:0] RPL_BYTE_OUT,
  output logic RPL_LAST_OUT,
  input wire logic RPL_READY_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire rsr_pkg::rsr_activity_type ACTIVITY_IN,
  output logic UART_RX_INDICATOR_OUT,
  output logic UART_TX_INDICATOR_OUT,
  output logic I2C_TRAFFIC_INDICATOR_OUT,
  output logic SUSPEND_INDICATOR_OUT,
  output logic USB_CONFIGURED_INDICATOR_OUT,
  output logic CLOCK_OUT
);
  import rsr_pkg::*;

  rsr_settings_type settings_ff;
  rsr_state_type state_ff;
  rsr_state_type nxt_state;
  logic [5:0] cmd_idx_ff;
  logic [7:0] cmd_code_ff;
  logic [7:0] rpl_code_ff;
  logic [5:0] rpl_idx_ff;
  logic [6:0] reply_cnt_ff;
  logic [6:0] take_cnt_ff;
  logic cmd_take;
  logic cmd_done;
  logic start;
  logic rpl_take;
  logic rpl_end;

  // ---------------------------------------------------------------------
  // Command reception
  // ---------------------------------------------------------------------
  assign cmd_take = CMD_VALID_IN && CMD_READY_OUT;
  assign cmd_done = cmd_take && (cmd_idx_ff == `RSR_IDX_LAST);
  assign start = cmd_done &&
    ((cmd_code_ff == `RSR_CODE_SET) || (cmd_code_ff == `RSR_CODE_GET)); // R17
  assign rpl_take = RPL_VALID_OUT && RPL_READY_IN;
  assign rpl_end = rpl_take && (rpl_idx_ff == `RSR_IDX_LAST);

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cmd_idx_ff <= `RSR_IDX_FIRST;
    end else if (cmd_take) begin
      cmd_idx_ff <= cmd_idx_ff + 6'h01;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cmd_code_ff <= 8'h00;
    end else if (cmd_take && (cmd_idx_ff == `RSR_IDX_FIRST)) begin
      cmd_code_ff <= CMD_BYTE_IN;
    end
  end

  // ---------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RSR_RECEIVE: begin
        if (start) begin
          nxt_state = RSR_REPLY;
        end
      end
      RSR_REPLY: begin
        if (rpl_end) begin
          nxt_state = RSR_RECEIVE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_ff <= RSR_RECEIVE;
      CMD_READY_OUT <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      CMD_READY_OUT <= (nxt_state == RSR_RECEIVE); // R17
    end
  end

  // ---------------------------------------------------------------------
  // Reply byte selection
  // ---------------------------------------------------------------------
  function automatic logic [7:0] reply_byte(input logic [5:0] idx,
      input logic [7:0] code, input rsr_settings_type s);
    reply_byte = `RSR_FILL;
    if (idx == `RSR_IDX_FIRST) begin
      reply_byte = code; // R1
    end else if (idx == `RSR_IDX_STATUS) begin
      reply_byte = `RSR_STATUS_OK; // R3
    end else if (code == `RSR_CODE_GET) begin
      case (idx)
        `RSR_IDX_CHIP_LEN: reply_byte = s.chip_len; // R4
        `RSR_IDX_GP_LEN: reply_byte = s.gp_len; // R4
        `RSR_IDX_FLAGS: reply_byte = s.flags; // R5
        `RSR_IDX_CLOCK: reply_byte = {3'h0, s.clock}; // R12
        `RSR_IDX_DAC: reply_byte = s.dac; // R13
        `RSR_IDX_EDGES: begin
          reply_byte[`RSR_EDGE_NEG_BIT] = s.edge_neg; // R16
          reply_byte[`RSR_EDGE_POS_BIT] = s.edge_pos;
        end
        default: reply_byte = `RSR_FILL;
      endcase
    end
  endfunction

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      RPL_VALID_OUT <= 1'b0;
      RPL_BYTE_OUT <= 8'h00;
      RPL_LAST_OUT <= 1'b0;
      rpl_idx_ff <= `RSR_IDX_FIRST;
    end else if (start) begin
      RPL_VALID_OUT <= 1'b1;
      RPL_BYTE_OUT <= cmd_code_ff; // R1
      RPL_LAST_OUT <= 1'b0;
      rpl_idx_ff <= `RSR_IDX_FIRST;
    end else if (rpl_end) begin
      RPL_VALID_OUT <= 1'b0; // R17
      RPL_BYTE_OUT <= 8'h00;
      RPL_LAST_OUT <= 1'b0;
    end else if (rpl_take) begin
      rpl_idx_ff <= rpl_idx_ff + 6'h01;
      RPL_BYTE_OUT <= reply_byte(rpl_idx_ff + 6'h01, rpl_code_ff,
        settings_ff);
      RPL_LAST_OUT <= (rpl_idx_ff + 6'h01 == `RSR_IDX_LAST);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rpl_code_ff <= 8'h00;
    end else if (start) begin
      rpl_code_ff <= cmd_code_ff;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      reply_cnt_ff <= 7'h00;
    end else if (rpl_end) begin
      reply_cnt_ff <= reply_cnt_ff + 7'h01;
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      settings_ff <= '0;
      settings_ff.chip_len <= `RSR_RST_CHIP_LEN;
      settings_ff.gp_len <= `RSR_RST_GP_LEN;
      settings_ff.flags <= `RSR_RST_FLAGS;
      settings_ff.clock <= `RSR_RST_CLOCK;
      settings_ff.dac <= `RSR_RST_DAC;
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        `RSR_REG_CHIP_LEN: settings_ff.chip_len <= REG_WDATA_IN;
        `RSR_REG_GP_LEN: settings_ff.gp_len <= REG_WDATA_IN;
        `RSR_REG_FLAGS: settings_ff.flags <= REG_WDATA_IN; // R11
        `RSR_REG_CLOCK: settings_ff.clock <= REG_WDATA_IN[4:0];
        `RSR_REG_DAC: settings_ff.dac <= REG_WDATA_IN; // R14 R15
        `RSR_REG_EDGES: begin
          settings_ff.edge_neg <= REG_WDATA_IN[`RSR_EDGE_NEG_BIT];
          settings_ff.edge_pos <= REG_WDATA_IN[`RSR_EDGE_POS_BIT];
        end
        `RSR_REG_ENABLES: begin
          {settings_ff.clock_en, settings_ff.cfg_en, settings_ff.susp_en,
            settings_ff.i2c_en} <= REG_WDATA_IN[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || !REG_RD_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      case (REG_ADDR_IN)
        `RSR_REG_CHIP_LEN: REG_RDATA_OUT <= settings_ff.chip_len;
        `RSR_REG_GP_LEN: REG_RDATA_OUT <= settings_ff.gp_len;
        `RSR_REG_FLAGS: REG_RDATA_OUT <= settings_ff.flags;
        `RSR_REG_CLOCK: REG_RDATA_OUT <= {3'h0, settings_ff.clock};
        `RSR_REG_DAC: REG_RDATA_OUT <= settings_ff.dac;
        `RSR_REG_EDGES: REG_RDATA_OUT <= reply_byte(`RSR_IDX_EDGES,
          `RSR_CODE_GET, settings_ff);
        `RSR_REG_ENABLES: REG_RDATA_OUT <= {4'h0, settings_ff.clock_en,
          settings_ff.cfg_en, settings_ff.susp_en, settings_ff.i2c_en};
        `RSR_REG_STATUS: REG_RDATA_OUT <= {reply_cnt_ff,
          (state_ff == RSR_REPLY)};
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Indicators and clock output
  // ---------------------------------------------------------------------
  rsr_indicator rx_ind (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .idle_level_in(settings_ff.flags.rx_idle), .enable_in(1'b1), // R6
    .active_in(ACTIVITY_IN.rx), .level_out(UART_RX_INDICATOR_OUT));
  rsr_indicator tx_ind (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .idle_level_in(settings_ff.flags.tx_idle), .enable_in(1'b1), // R7
    .active_in(ACTIVITY_IN.tx), .level_out(UART_TX_INDICATOR_OUT));
  rsr_indicator i2c_ind (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .idle_level_in(settings_ff.flags.i2c_idle), // R8
    .enable_in(settings_ff.i2c_en), .active_in(ACTIVITY_IN.i2c),
    .level_out(I2C_TRAFFIC_INDICATOR_OUT));
  rsr_indicator susp_ind (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .idle_level_in(settings_ff.flags.susp_idle), // R9
    .enable_in(settings_ff.susp_en), .active_in(ACTIVITY_IN.suspend),
    .level_out(SUSPEND_INDICATOR_OUT));
  rsr_indicator cfg_ind (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .idle_level_in(settings_ff.flags.cfg_idle), // R10
    .enable_in(settings_ff.cfg_en), .active_in(ACTIVITY_IN.configured),
    .level_out(USB_CONFIGURED_INDICATOR_OUT));

  rsr_clock_divider clk_div (.clk_in(SYS_CLK_IN), .rst_in(RST_IN),
    .enable_in(settings_ff.clock_en), .div_in(settings_ff.clock.div), // R12
    .duty_in(settings_ff.clock.duty), .clock_out(CLOCK_OUT));

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || start) begin
      take_cnt_ff <= 7'h00;
    end else if (rpl_take) begin
      take_cnt_ff <= take_cnt_ff + 7'h01;
    end
  end

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence step_s(logic [5:0] n);
    rpl_take && (rpl_idx_ff == n);
  endsequence

  sequence get_step_s(logic [5:0] n);
    step_s(n) ##0 (rpl_code_ff == `RSR_CODE_GET);
  endsequence

  echo_code_a: assert property (start |=> RPL_VALID_OUT && // R3
      (RPL_BYTE_OUT == $past(cmd_code_ff)) && !CMD_READY_OUT)
    else $error("Reply does not open with the command code.");
  status_ok_a: assert property (step_s(`RSR_IDX_FIRST) |=> // R1
      RPL_BYTE_OUT == `RSR_STATUS_OK)
    else $error("Reply status byte is not success.");
  area_len_a: assert property (get_step_s(`RSR_IDX_FIRST + 6'h01) |=> // R4
      RPL_BYTE_OUT == $past(settings_ff.chip_len))
    else $error("Chip area length byte is wrong.");
  flags_byte_a: assert property (get_step_s(`RSR_IDX_GP_LEN) |=> // R5
      RPL_BYTE_OUT == $past(settings_ff.flags))
    else $error("Flag byte does not match the settings.");
  clock_byte_a: assert property (get_step_s(`RSR_IDX_FLAGS) |=> // R12
      RPL_BYTE_OUT == {3'h0, $past(settings_ff.clock)})
    else $error("Clock output byte does not match the settings.");
  dac_byte_a: assert property (get_step_s(`RSR_IDX_CLOCK) |=> // R13
      RPL_BYTE_OUT == $past(settings_ff.dac))
    else $error("DAC byte does not match the settings.");
  edge_byte_a: assert property (get_step_s(`RSR_IDX_DAC) |=> // R16
      RPL_BYTE_OUT[6:5] ==
      $past({settings_ff.edge_neg, settings_ff.edge_pos}))
    else $error("Edge byte does not match the settings.");
  rx_indicator_a: assert property (ACTIVITY_IN.rx |=> // R6
      UART_RX_INDICATOR_OUT == !$past(settings_ff.flags.rx_idle))
    else $error("Receive indicator not inverted during activity.");
  tx_indicator_a: assert property (!ACTIVITY_IN.tx |=> // R7
      UART_TX_INDICATOR_OUT == $past(settings_ff.flags.tx_idle))
    else $error("Transmit indicator not at idle level.");
  suspend_level_a: assert property (ACTIVITY_IN.suspend && // R9
      settings_ff.susp_en |=>
      SUSPEND_INDICATOR_OUT == !$past(settings_ff.flags.susp_idle))
    else $error("Suspend indicator not inverted in suspend.");
  reply_length_a: assert property ($fell(RPL_VALID_OUT) |-> // R17
      take_cnt_ff == `RSR_REPORT_BYTES)
    else $error("Reply did not carry exactly 64 bytes.");
  reply_end_a: assert property (rpl_end |=> !RPL_VALID_OUT && // R17
      CMD_READY_OUT && !RPL_LAST_OUT)
    else $error("Reply did not end after its last byte.");

endmodule

`default_nettype wire

// >>> rsr_consts.svh
/*
  Constants of the run-time settings report block: command codes, report
  geometry, register offsets and reset values.
  Assumes it is included by bare name after the package has been compiled.
*/
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH

// ---------------------------------------------------------------------
// Command codes and status
// ---------------------------------------------------------------------
`define RSR_CODE_SET 8'h60
`define RSR_CODE_GET 8'h61
`define RSR_STATUS_OK 8'h00
`define RSR_FILL 8'h00

// ---------------------------------------------------------------------
// Report geometry and reply byte positions
// ---------------------------------------------------------------------
`define RSR_IDX_FIRST 6'h00
`define RSR_IDX_STATUS 6'h01
`define RSR_IDX_CHIP_LEN 6'h02
`define RSR_IDX_GP_LEN 6'h03
`define RSR_IDX_FLAGS 6'h04
`define RSR_IDX_CLOCK 6'h05
`define RSR_IDX_DAC 6'h06
`define RSR_IDX_EDGES 6'h07
`define RSR_IDX_LAST 6'h3f
`define RSR_REPORT_BYTES 7'h40

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define RSR_REG_CHIP_LEN 4'h0
`define RSR_REG_GP_LEN 4'h1
`define RSR_REG_FLAGS 4'h2
`define RSR_REG_CLOCK 4'h3
`define RSR_REG_DAC 4'h4
`define RSR_REG_EDGES 4'h5
`define RSR_REG_ENABLES 4'h6
`define RSR_REG_STATUS 4'h7

// ---------------------------------------------------------------------
// Field positions in the edge byte, and reset values
// ---------------------------------------------------------------------
`define RSR_EDGE_NEG_BIT 6
`define RSR_EDGE_POS_BIT 5
`define RSR_RST_CHIP_LEN 8'h00
`define RSR_RST_GP_LEN 8'h00
`define RSR_RST_FLAGS 8'h00
`define RSR_RST_CLOCK 5'h00
`define RSR_RST_DAC 8'h00

`endif

// >>> rsr_pkg.sv
/*
  Types of the run-time settings report block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rsr_pkg;

  // -------------------------------------------------------------------
  // Settings, all but the four output enables carried by the reply
  // -------------------------------------------------------------------
  typedef struct packed {
    logic serial_en;
    logic rx_idle;
    logic tx_idle;
    logic i2c_idle;
    logic susp_idle;
    logic cfg_idle;
    logic [1:0] security;
  } rsr_flags_type;

  typedef struct packed {
    logic [1:0] duty;
    logic [2:0] div;
  } rsr_clock_type;

  typedef struct packed {
    logic [1:0] level;
    logic src_internal;
    logic [4:0] powerup;
  } rsr_dac_type;

  typedef struct packed {
    logic [7:0] chip_len;
    logic [7:0] gp_len;
    rsr_flags_type flags;
    rsr_clock_type clock;
    rsr_dac_type dac;
    logic edge_neg;
    logic edge_pos;
    logic clock_en;
    logic cfg_en;
    logic susp_en;
    logic i2c_en;
  } rsr_settings_type;

  // -------------------------------------------------------------------
  // Activity of the surrounding device
  // -------------------------------------------------------------------
  typedef struct packed {
    logic rx;
    logic tx;
    logic i2c;
    logic suspend;
    logic configured;
  } rsr_activity_type;

  typedef enum logic {RSR_RECEIVE, RSR_REPLY} rsr_state_type;

endpackage

// >>> rsr_indicator.sv
/*
  One activity indicator: shows its idle level, or the inverse of it while
  enabled and active.
  Assumes activity and settings are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rsr_indicator (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic idle_level_in,
  input wire logic enable_in,
  input wire logic active_in,
  output logic level_out
);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else begin
      level_out <= (enable_in && active_in) ? ~idle_level_in : idle_level_in;
    end
  end

endmodule

`default_nettype wire

// >>> rsr_clock_divider.sv
/*
  Clock output generator: divides the system clock by a power of two and
  shapes the high time from the duty field.
  Assumes divider and duty are steady while the output is enabled.
*/
`timescale 1ns/1ps
`default_nettype none

module rsr_clock_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [2:0] div_in,
  input wire logic [1:0] duty_in,
  output logic clock_out
);

  logic [7:0] cnt_ff;
  logic [8:0] period;
  logic [8:0] high_time;

  // ---------------------------------------------------------------------
  // Period and high time
  // ---------------------------------------------------------------------
  always_comb begin
    period = 9'h002 << div_in;
    unique case (duty_in)
      2'h1: high_time = period >> 2;
      2'h2: high_time = period - (period >> 2);
      default: high_time = period >> 1;
    endcase
  end

  // ---------------------------------------------------------------------
  // Counter and output
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in || ({1'b0, cnt_ff} == period - 9'h001)) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clock_out <= 1'b0;
    end else begin
      clock_out <= enable_in && ({1'b0, cnt_ff} < high_time);
    end
  end

endmodule

`default_nettype wire

// >>> rsr_host_model.sv
/*
  Host model: sends 64-byte command reports and takes 64-byte replies,
  either at full rate or stalling on every other cycle.
  Assumes it shares the block's clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rsr_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [7:0] code_in,
  input wire logic slow_in,
  input wire logic cmd_ready_in,
  input wire logic rpl_valid_in,
  input wire logic [7:0] rpl_byte_in,
  input wire logic rpl_last_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic rpl_ready_out,
  output logic [6:0] rpl_count_out,
  output logic [6:0] last_idx_out,
  output logic [7:0] rpl_mem_out [0:63]
);
  logic sending, tick, more, taken, send;
  logic [5:0] idx, nidx;
  logic [7:0] code_ff;

  // ---------------------------------------------------------------
  // Command side
  // ---------------------------------------------------------------
  assign taken = cmd_valid_out && cmd_ready_in;
  assign more = go_in || (sending && !(taken && idx == 6'h3f));
  assign nidx = go_in ? 6'h00 : (taken ? idx + 6'h01 : idx);
  assign send = more && (!slow_in || tick);

  always @(posedge clk_in) begin
    if (rst_in) begin
      sending <= 1'b0;
      idx <= 6'h00;
      tick <= 1'b0;
      code_ff <= 8'h00;
      cmd_valid_out <= 1'b0;
      cmd_byte_out <= 8'h00;
    end else begin
      tick <= ~tick;
      sending <= more;
      idx <= nidx;
      if (go_in) begin
        code_ff <= code_in;
      end
      // A byte is held until taken; an idle bus shows the inverse value.
      if (!(cmd_valid_out && !cmd_ready_in)) begin
        cmd_valid_out <= send;
        cmd_byte_out <= !send ? ~cmd_byte_out :
          (nidx != 6'h00 ? 8'h00 : (go_in ? code_in : code_ff));
      end
    end
  end

  // ---------------------------------------------------------------
  // Reply side
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in || go_in) begin
      rpl_count_out <= 7'h00;
      last_idx_out <= 7'h7f;
      rpl_ready_out <= 1'b0;
    end else begin
      rpl_ready_out <= !slow_in || tick;
      if (rpl_valid_in && rpl_ready_out) begin
        rpl_mem_out[rpl_count_out[5:0]] <= rpl_byte_in;
        rpl_count_out <= rpl_count_out + 7'h01;
        if (rpl_last_in) begin
          last_idx_out <= rpl_count_out;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
/*
  Self-checking testbench of the run-time settings report block.
  Assumes the package, the constants header and the host model compiled.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, sn) \
  begin \
    check_count++; \
    if ((sn) !== (ex)) begin \
      err_total++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn); \
    end \
  end

module testbench;
  import rsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [7:0] code = 8'h00;
  logic cmd_valid, cmd_ready, rpl_valid, rpl_last, rpl_ready;
  logic [7:0] cmd_byte, rpl_byte;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  rsr_activity_type act = '0;
  logic ind_rx, ind_tx, ind_i2c, ind_susp, ind_cfg, clk_o;
  logic [6:0] rpl_count, last_idx;
  logic [7:0] rpl_mem [0:63];
  logic [7:0] regs [0:6];
  logic [31:0] seed = 32'ha956;
  int err_total = 0;
  int check_count = 0;
  int replies = 0;

  always #5 clk = ~clk;

  rsr_settings_report dut (.SYS_CLK_IN(clk), .RST_IN(rst),
    .CMD_VALID_IN(cmd_valid), .CMD_BYTE_IN(cmd_byte),
    .CMD_READY_OUT(cmd_ready), .RPL_VALID_OUT(rpl_valid),
    .RPL_BYTE_OUT(rpl_byte), .RPL_LAST_OUT(rpl_last),
    .RPL_READY_IN(rpl_ready), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(reg_rdata), .ACTIVITY_IN(act),
    .UART_RX_INDICATOR_OUT(ind_rx), .UART_TX_INDICATOR_OUT(ind_tx),
    .I2C_TRAFFIC_INDICATOR_OUT(ind_i2c), .SUSPEND_INDICATOR_OUT(ind_susp),
    .USB_CONFIGURED_INDICATOR_OUT(ind_cfg), .CLOCK_OUT(clk_o));

  rsr_host_model host (.clk_in(clk), .rst_in(rst), .go_in(go),
    .code_in(code), .slow_in(slow), .cmd_ready_in(cmd_ready),
    .rpl_valid_in(rpl_valid), .rpl_byte_in(rpl_byte),
    .rpl_last_in(rpl_last), .cmd_valid_out(cmd_valid),
    .cmd_byte_out(cmd_byte), .rpl_ready_out(rpl_ready),
    .rpl_count_out(rpl_count), .last_idx_out(last_idx),
    .rpl_mem_out(rpl_mem));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] mask(input int a);
    return a == 3 ? 8'h1f : (a == 5 ? 8'h60 : (a == 6 ? 8'h0f : 8'hff));
  endfunction

  function automatic logic [7:0] exp_get(input int i);
    case (i)
      0: return 8'h61;
      2, 3, 4, 5, 6, 7: return regs[i - 2] & mask(i - 2);
      default: return 8'h00;
    endcase
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cmd_t(input logic [7:0] c, input logic s, input logic r);
    int n;
    @(posedge clk);
    go <= 1'b1;
    code <= c;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (r && rpl_count == 7'h40 && rpl_valid === 1'b0) break;
    end
    if (r && n == 400) begin
      err_total++;
      $display("MISMATCH reply expected done seen timeout");
      finish_test();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] v, e, hi;
    int i, k;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("cmd_ready", 1'b1, cmd_ready)
    for (i = 0; i < 7; i++) begin
      v = rnd8();
      regs[i] = v;
      reg_wr_t(4'(i), v);
    end
    reg_wr_t(4'h7, 8'hff);
    reg_wr_t(4'h9, 8'hff);
    for (i = 0; i < 7; i++) begin
      reg_rd_t(4'(i), v);
      `CHK("reg", regs[i] & mask(i), v)
    end
    reg_rd_t(4'h9, v);
    `CHK("unmapped", 8'h00, v)
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 7; i++) begin
        v = rnd8();
        regs[i] = v;
      end
      regs[2][1:0] = k == 3 ? 2'b10 : 2'(k);
      regs[4][7:6] = 2'(k);
      if (k == 0) regs[2] = 8'hfc;
      for (i = 0; i < 7; i++) reg_wr_t(4'(i), regs[i]);
      cmd_t(8'h61, k[0], 1'b1);
      replies++;
      `CHK("echo", 8'h61, rpl_mem[0])
      `CHK("status", 8'h00, rpl_mem[1])
      `CHK("serial", regs[2][7], rpl_mem[4][7])
      `CHK("security", regs[2][1:0], rpl_mem[4][1:0])
      `CHK("clock", regs[3] & 8'h1f, rpl_mem[5])
      `CHK("dac_level", regs[4][7:6], rpl_mem[6][7:6])
      `CHK("dac_src", regs[4][5], rpl_mem[6][5])
      `CHK("dac_pwr", regs[4][4:0], rpl_mem[6][4:0])
      `CHK("edges", regs[5] & 8'h60, rpl_mem[7])
      for (i = 0; i < 64; i++) `CHK("byte", exp_get(i), rpl_mem[i])
      `CHK("count", 7'h40, rpl_count)
      `CHK("last", 7'h3f, last_idx)
      `CHK("ready_back", 1'b1, cmd_ready)
    end
    $display("test get done");
    cmd_t(8'h60, 1'b1, 1'b1);
    replies++;
    `CHK("set_echo", 8'h60, rpl_mem[0])
    `CHK("set_status", 8'h00, rpl_mem[1])
    `CHK("set_count", 7'h40, rpl_count)
    cmd_t(8'h55, 1'b0, 1'b0);
    `CHK("no_reply", 7'h00, rpl_count)
    reg_rd_t(4'h7, v);
    `CHK("status_reg", {7'(replies), 1'b0}, v)
    $display("test set done");
    for (k = 0; k < 24; k++) begin
      v = rnd8();
      e = rnd8();
      reg_wr_t(4'h2, v);
      reg_wr_t(4'h6, e & 8'h07);
      act <= rsr_activity_type'(e[7:3]);
      repeat (2) @(posedge clk);
      #1;
      `CHK("rx_ind", v[6] ^ e[7], ind_rx)
      `CHK("tx_ind", v[5] ^ e[6], ind_tx)
      `CHK("i2c_ind", v[4] ^ (e[5] & e[0]), ind_i2c)
      `CHK("susp_ind", v[3] ^ (e[4] & e[1]), ind_susp)
      `CHK("cfg_ind", v[2] ^ (e[3] & e[2]), ind_cfg)
    end
    $display("test indicators done");
    for (k = 0; k < 6; k++) begin
      reg_wr_t(4'h6, k == 5 ? 8'h00 : 8'h08);
      reg_wr_t(4'h3, k == 4 ? 8'h05 : {3'h0, 2'(k), 3'h2});
      repeat (16) @(posedge clk);
      hi = 8'h00;
      repeat (64) begin
        @(posedge clk);
        #1 hi = hi + {7'h00, clk_o};
      end
      e = k == 5 ? 8'd0 : (k == 1 ? 8'd16 : (k == 2 ? 8'd48 : 8'd32));
      `CHK("clock_high", e, hi)
    end
    $display("test clock done");
    finish_test();
  end
endmodule
`default_nettype wire
